// [design/fifo_i2c_irq_autovector.sv]
// Two-wire-bus interrupt and shared FIFO/waveform autovectored interrupt
`timescale 1ns/10ps
module fifo_i2c_irq_autovector
	import irq_vec_pkg::*;
#(
	parameter int NSRC = 14
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Two-wire-bus controller status
	input wire logic i_bus_done,
	input wire logic i_bus_stop,
	input wire access_s i_bus_data_access,
	input wire access_s i_bus_ctrl_access,
	// Enables and setup
	input wire logic [7:0] i_ext_irq_enable_reg,
	input wire logic i_stop_source_enable,
	input wire logic i_fifo_autovector_enable,
	// Flag register write port
	input wire logic i_ext_irq_flag_wr,
	input wire logic [7:0] i_ext_irq_flag_wdata,
	// Individual sources, bit 0 is ep_two_prog_flag ... bit 13 waveform_trigger_flag
	input wire logic [NSRC-1:0] i_src_event,
	input wire logic [NSRC-1:0] i_src_enable,
	input wire logic i_src_latch_wr,
	input wire logic [NSRC-1:0] i_src_latch_wdata,
	// Program fetch path
	input wire fetch_s i_fetch,
	// Outputs
	output logic o_bus_irq,
	output logic [7:0] o_bus_ctrl_status_reg,
	output logic o_fifo_wave_main_irq,
	output logic [7:0] o_fifo_wave_vector_reg,
	output logic [NSRC-1:0] o_src_latch,
	output logic [7:0] o_ext_irq_flag_reg,
	output fetch_s o_fetch
);
`include "irq_vec_defs.svh"

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Edges of a level between its registered copy and its present value
	function automatic logic rose_now(
		input logic prev,
		input logic now
	);
		return now && !prev;
	endfunction

	function automatic logic fell_now(
		input logic prev,
		input logic now
	);
		return prev && !now;
	endfunction

	// A flag write clears a request when it carries zero in that bit
	function automatic logic zero_written(
		input logic wr,
		input logic [7:0] wdata,
		input int pos
	);
		return wr && !wdata[pos];
	endfunction

	// Either half of a register access strobe
	function automatic logic touched(
		input access_s acc
	);
		return acc.rd || acc.wr;
	endfunction

	// Status image: done and stop in place, the rest reads zero
	function automatic logic [7:0] status_image(
		input logic done,
		input logic stop
	);
		logic [7:0] img;
		img = 8'h00;
		img[`BUS_DONE_BIT] = done;
		img[`BUS_STOP_BIT] = stop;
		return img;
	endfunction

	// Flag image: the two requests in their bit positions
	function automatic logic [7:0] flag_image(
		input logic bus,
		input logic main
	);
		logic [7:0] img;
		img = 8'h00;
		img[`FLAG_BUS_BIT] = bus;
		img[`FLAG_MAIN_BIT] = main;
		return img;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Two-wire-bus interrupt

	logic prev_done;
	logic prev_stop;
	logic bus_irq;
	logic next_prev_done;
	logic next_prev_stop;
	logic next_bus_irq;
	logic done_rise;
	logic stop_fall;
	logic done_source;
	logic stop_source;
	logic bus_clear;

	always_comb begin
		done_rise = rose_now(prev_done, i_bus_done);
		stop_fall = fell_now(prev_stop, i_bus_stop);
		done_source = done_rise && i_ext_irq_enable_reg[`EXT_EN_BUS_BIT];
		// Stop rides on the same enable and needs its own as well
		stop_source = stop_fall && i_ext_irq_enable_reg[`EXT_EN_BUS_BIT]
			&& i_stop_source_enable;
		// Clear by flag write of zero or by any bus register access
		bus_clear = zero_written(i_ext_irq_flag_wr, i_ext_irq_flag_wdata, `FLAG_BUS_BIT)
			|| touched(i_bus_data_access)
			|| touched(i_bus_ctrl_access);
		next_prev_done = i_bus_done;
		next_prev_stop = i_bus_stop;
		next_bus_irq = bus_irq;
		if (bus_clear) begin
			next_bus_irq = 1'b0;
		end
		// A new event wins over a clear in the same cycle
		if (done_source || stop_source) begin
			next_bus_irq = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			// Track the pins through reset so an idle-high done is no edge
			prev_done <= i_bus_done;
			prev_stop <= i_bus_stop;
			bus_irq <= 1'b0;
		end else begin
			prev_done <= next_prev_done;
			prev_stop <= next_prev_stop;
			bus_irq <= next_bus_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Individual FIFO/waveform latches and main request

	logic [NSRC-1:0] latch;
	logic main_irq;
	logic [NSRC-1:0] next_latch;
	logic next_main_irq;
	logic [NSRC-1:0] pending;
	logic [NSRC-1:0] prev_pending;
	logic [NSRC-1:0] next_prev_pending;
	logic [NSRC-1:0] cleared_now;
	logic [NSRC-1:0] left_pending;
	logic [7:0] code;
	logic newly_pending;
	logic clear_leaves_pending;
	logic main_clear;
	logic main_trigger;

	assign pending = latch & i_src_enable;

	vec_prio_enc #(
		.N(NSRC)
	) u_enc (
		.i_pending(pending),
		.o_code(code),
		.o_any()
	);

	always_comb begin
		cleared_now = '0;
		if (i_src_latch_wr) begin
			cleared_now = latch & i_src_latch_wdata;
		end
		// A new event wins over a clear of the same latch
		next_latch = (latch & ~cleared_now) | i_src_event;
		left_pending = pending & ~cleared_now;
		next_prev_pending = pending;
		// Main request is attempted on any newly pending source, or when a
		// latch clear leaves others pending
		newly_pending = |(pending & ~prev_pending);
		clear_leaves_pending = (|cleared_now) && (|left_pending);
		main_trigger = newly_pending || clear_leaves_pending;
		main_clear = zero_written(i_ext_irq_flag_wr, i_ext_irq_flag_wdata,
			`FLAG_MAIN_BIT);
		next_main_irq = main_irq;
		if (main_clear) begin
			next_main_irq = 1'b0;
		end
		// An attempt while the main request is still set is dropped
		if (main_trigger && !main_irq) begin
			next_main_irq = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			latch <= '0;
			main_irq <= 1'b0;
			prev_pending <= '0;
		end else begin
			latch <= next_latch;
			main_irq <= next_main_irq;
			prev_pending <= next_prev_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Vector patching on the entry jump fetch

	fetch_s next_fetch;
	logic patch_hit;

	always_comb begin
		// Only the low target byte of the entry jump is replaced
		patch_hit = i_fetch.valid && (i_fetch.addr == `ENTRY_LO_ADDR)
			&& i_fifo_autovector_enable;
		next_fetch = i_fetch;
		if (patch_hit) begin
			next_fetch.data = code;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_fetch <= '0;
		end else begin
			o_fetch <= next_fetch;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered copies of the bus request and status

	logic [7:0] next_status;
	logic next_bus_out;

	always_comb begin
		next_status = status_image(i_bus_done, i_bus_stop);
		next_bus_out = next_bus_irq;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_bus_ctrl_status_reg <= 8'h00;
			o_bus_irq <= 1'b0;
		end else begin
			o_bus_ctrl_status_reg <= next_status;
			o_bus_irq <= next_bus_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered copies of the main request, vector and latches

	logic [7:0] next_flag;
	logic [7:0] next_vector;
	logic next_main_out;
	logic [NSRC-1:0] next_src_out;

	always_comb begin
		// Vector trails the latches by one cycle; a fetch sees the live code
		next_vector = code;
		next_flag = flag_image(next_bus_irq, next_main_irq);
		next_main_out = next_main_irq;
		next_src_out = next_latch;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_ext_irq_flag_reg <= 8'h00;
			o_fifo_wave_vector_reg <= `VEC_EMPTY_CODE;
			o_fifo_wave_main_irq <= 1'b0;
			o_src_latch <= '0;
		end else begin
			o_ext_irq_flag_reg <= next_flag;
			o_fifo_wave_vector_reg <= next_vector;
			o_fifo_wave_main_irq <= next_main_out;
			o_src_latch <= next_src_out;
		end
	end
endmodule // fifo_i2c_irq_autovector

// [design/irq_vec_defs.svh]
// Constants for the FIFO/waveform and two-wire-bus interrupt block
`ifndef IRQ_VEC_DEFS_SVH
`define IRQ_VEC_DEFS_SVH
`define BUS_DONE_BIT 0
`define BUS_STOP_BIT 6
`define EXT_EN_BUS_BIT 1
`define FLAG_BUS_BIT 5
`define FLAG_MAIN_BIT 6
`define VEC_BASE 8'h80
`define VEC_EMPTY_CODE 8'h80
`define ENTRY_ADDR 16'h0053
`define ENTRY_HI_ADDR 16'h0054
`define ENTRY_LO_ADDR 16'h0055
`define NUM_SOURCES 14
`endif

// [design/irq_vec_pkg.sv]
// Types shared by the interrupt block
package irq_vec_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
		logic valid;
	} fetch_s;
	typedef struct packed {
		logic rd;
		logic wr;
	} access_s;
endpackage

// [design/vec_prio_enc.sv]
// Fixed-priority encoder that turns pending sources into a vector code
`timescale 1ns/10ps
module vec_prio_enc #(
	parameter int N = 14
) (
	// Pending sources, bit 0 highest priority
	input wire logic [N-1:0] i_pending,
	// Vector code and any-pending flag
	output logic [7:0] o_code,
	output logic o_any
);
`include "irq_vec_defs.svh"
	always_comb begin
		o_code = `VEC_EMPTY_CODE;
		o_any = 1'b0;
		// Scan downward so the lowest index wins
		for (int k = N - 1; k >= 0; k--) begin
			if (i_pending[k]) begin
				o_code = `VEC_BASE + 8'(k * 4);
				o_any = 1'b1;
			end
		end
	end
endmodule // vec_prio_enc

// [tb/irq_props_properties.sv]
// Assertions on the ports of the interrupt block
`timescale 1ns/10ps
`include "irq_vec_defs.svh"
module irq_props
	import irq_vec_pkg::*;
#(
	parameter int NSRC = 14
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_bus_done,
	input wire logic i_bus_stop,
	input wire access_s i_bus_data_access,
	input wire access_s i_bus_ctrl_access,
	input wire logic [7:0] i_ext_irq_enable_reg,
	input wire logic i_stop_source_enable,
	input wire logic i_fifo_autovector_enable,
	input wire logic i_ext_irq_flag_wr,
	input wire logic [7:0] i_ext_irq_flag_wdata,
	input wire logic [NSRC-1:0] i_src_enable,
	input wire fetch_s i_fetch,
	input wire logic o_bus_irq,
	input wire logic [7:0] o_bus_ctrl_status_reg,
	input wire logic o_fifo_wave_main_irq,
	input wire logic [7:0] o_fifo_wave_vector_reg,
	input wire logic [NSRC-1:0] o_src_latch,
	input wire fetch_s o_fetch
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	logic [7:0] want;
	logic [1:0] rs;
	wire any_pend = |(o_src_latch & i_src_enable);
	wire patch = i_fifo_autovector_enable && i_fetch.valid && i_fetch.addr == `ENTRY_LO_ADDR;
	// Two clean edges needed: outputs may still read zero on the first one
	always_ff @(posedge i_clk) rs <= {rs[0], i_reset};
	always_comb begin
		want = `VEC_BASE;
		for (int k = NSRC - 1; k >= 0; k--)
			if (o_src_latch[k] && i_src_enable[k]) want = `VEC_BASE + 8'(4 * k);
	end
	property p_done; $rose(i_bus_done) && i_ext_irq_enable_reg[1] |=> o_bus_irq; endproperty
	a_done: assert property (p_done) else $error("bus irq missed done rise");
	property p_stop; $fell(i_bus_stop) && i_ext_irq_enable_reg[1] && i_stop_source_enable |=> o_bus_irq;
	endproperty
	a_stop: assert property (p_stop) else $error("bus irq missed stop fall");
	property p_en; !o_bus_irq && !i_ext_irq_enable_reg[1] |=> !o_bus_irq; endproperty
	a_en: assert property (p_en) else $error("bus irq while disabled");
	property p_stat; rs == 2'h0 |-> o_bus_ctrl_status_reg ==
		{1'b0, $past(i_bus_stop), 5'h00, $past(i_bus_done)}; endproperty
	a_stat: assert property (p_stat) else $error("status copy wrong");
	property p_bus_clr; o_bus_irq && !$rose(i_bus_done) && !$fell(i_bus_stop) &&
		(|{i_bus_data_access, i_bus_ctrl_access} || i_ext_irq_flag_wr && !i_ext_irq_flag_wdata[5])
		|=> !o_bus_irq; endproperty
	a_bus_clr: assert property (p_bus_clr) else $error("bus irq not cleared");
	property p_vec; rs == 2'h0 |-> o_fifo_wave_vector_reg == $past(want); endproperty
	a_vec: assert property (p_vec) else $error("vector code wrong");
	property p_main_set; $rose(any_pend) |=> o_fifo_wave_main_irq; endproperty
	a_main_set: assert property (p_main_set) else $error("main irq not raised");
	property p_hold; o_fifo_wave_main_irq && !(i_ext_irq_flag_wr && !i_ext_irq_flag_wdata[6])
		|=> o_fifo_wave_main_irq; endproperty
	a_hold: assert property (p_hold) else $error("main irq dropped");
	property p_fetch; rs == 2'h0 |-> o_fetch == {$past(i_fetch.addr), $past(patch) ?
		$past(want) : $past(i_fetch.data), $past(i_fetch.valid)}; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch byte wrong");
	c_lost: cover property (o_fifo_wave_main_irq && o_src_latch[13]);
	c_patch: cover property (patch);
	c_bus: cover property ($fell(o_bus_irq));
endmodule // irq_props
bind fifo_i2c_irq_autovector irq_props #(.NSRC(NSRC)) props (.*);

// [tb/cpu_fetch_model.sv]
// Processor model that takes the shared interrupt and fetches the entry jump
`timescale 1ns/10ps
module cpu_fetch_model
	import irq_vec_pkg::*;
#(
	parameter logic [7:0] PAGE = 8'h04
) (
	input wire logic i_clk,
	input wire logic i_irq,
	input wire logic i_take,
	output fetch_s o_fetch
);
	int step = 0;
	logic [7:0] rom [4] = '{8'h00, 8'h02, PAGE, 8'h80};
	initial o_fetch = '0;
	// Idle data inverts each cycle so a stale byte is never mistaken for a fetch
	always @(posedge i_clk) begin
		o_fetch.valid <= step != 0;
		o_fetch.addr <= 16'h0052 + 16'(step);
		o_fetch.data <= step != 0 ? rom[step] : ~o_fetch.data;
		step <= step == 3 ? 0 : (step != 0 || (i_irq && i_take)) ? step + 1 : 0;
	end
endmodule // cpu_fetch_model

// [tb/tb_top.sv]
// Self-checking bench for the interrupt block
`timescale 1ns/10ps
module tb_top
	import irq_vec_pkg::*;
;
	logic i_clk = 0, i_reset = 1, i_bus_done = 0, i_bus_stop = 0, i_stop_source_enable = 0;
	logic i_fifo_autovector_enable = 0, i_ext_irq_flag_wr = 0, i_src_latch_wr = 0, take = 0;
	access_s i_bus_data_access = '0, i_bus_ctrl_access = '0;
	logic [7:0] i_ext_irq_enable_reg = 8'h00, i_ext_irq_flag_wdata = 8'h00;
	logic [13:0] i_src_event = '0, i_src_enable = '1, i_src_latch_wdata = '0, o_src_latch;
	fetch_s i_fetch, o_fetch;
	logic o_bus_irq, o_fifo_wave_main_irq;
	logic [7:0] o_bus_ctrl_status_reg, o_fifo_wave_vector_reg, o_ext_irq_flag_reg;
	int n_mismatch = 0, tests_run = 0;
	fifo_i2c_irq_autovector #(.NSRC(14)) dut (.*);
	cpu_fetch_model cpu (.i_clk, .i_irq(o_fifo_wave_main_irq), .i_take(take), .o_fetch(i_fetch));
	initial forever #25 i_clk = ~i_clk;
	task automatic cyc(int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic evt(logic [13:0] v);
		i_src_event = v;
		cyc(1);
		i_src_event = '0;
		cyc(1);
	endtask
	task automatic lclr(logic [13:0] v);
		i_src_latch_wr = 1;
		i_src_latch_wdata = v;
		cyc(1);
		i_src_latch_wr = 0;
		cyc(2);
	endtask
	task automatic flagw(logic [7:0] d);
		i_ext_irq_flag_wr = 1;
		i_ext_irq_flag_wdata = d;
		cyc(1);
		i_ext_irq_flag_wr = 0;
	endtask
	task automatic fetch(logic [7:0] e);
		take = 1;
		repeat (8) begin
			cyc(1);
			take = 0;
			if (o_fetch.valid === 1'b1 && o_fetch.addr === 16'h0055) break;
		end
		chk("fetch", e, o_fetch.data);
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#60us;
		n_mismatch++;
		tally_and_finish;
	end
	////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(6);
		i_reset = 0;
		cyc(1);
		chk("vec_idle", 16'h0080, o_fifo_wave_vector_reg);
		for (int k = 0; k < 14; k++) begin
			evt(14'(1 << k));
			chk("vec", 16'h0080 + 16'(4 * k), o_fifo_wave_vector_reg);
			chk("main", 1, o_fifo_wave_main_irq);
			flagw(8'h00);
			chk("main_clr", 0, o_fifo_wave_main_irq);
			lclr(14'(1 << k));
			chk("latch", 0, o_src_latch);
		end
		i_src_enable = '0;
		evt(14'h0810);
		chk("masked", 0, o_fifo_wave_main_irq);
		i_src_enable = '1;
		cyc(2);
		chk("vec_two", 16'h0090, o_fifo_wave_vector_reg);
		i_fifo_autovector_enable = 1;
		fetch(8'h90);
		flagw(8'h00);
		lclr(14'h0010);
		chk("rearm", 1, o_fifo_wave_main_irq);
		chk("vec_next", 16'h00AC, o_fifo_wave_vector_reg);
		evt(14'h2000);
		lclr(14'h0800);
		flagw(8'h00);
		cyc(2);
		chk("lost", 0, o_fifo_wave_main_irq);
		chk("vec_last", 16'h00B4, o_fifo_wave_vector_reg);
		lclr(14'h2000);
		i_fifo_autovector_enable = 0;
		evt(14'h1000);
		fetch(8'h80);
		i_ext_irq_enable_reg = 8'h02;
		for (int k = 0; k < 5; k++) begin
			i_bus_done = 0;
			cyc(1);
			i_bus_done = 1;
			cyc(2);
			chk("bus_set", 1, o_bus_irq);
			chk("status", 16'h0001, o_bus_ctrl_status_reg);
			// Accesses on the first four rounds, a flag write of zero in bit 5 on the last
			if (k < 4) begin
				{i_bus_data_access, i_bus_ctrl_access} = 4'(1 << k);
				cyc(1);
				{i_bus_data_access, i_bus_ctrl_access} = 4'h0;
			end else flagw(8'hDF);
			cyc(1);
			chk("bus_clr", 0, o_bus_irq);
		end
		i_bus_stop = 1;
		cyc(2);
		i_bus_stop = 0;
		cyc(2);
		chk("stop_off", 0, o_bus_irq);
		i_stop_source_enable = 1;
		i_bus_stop = 1;
		cyc(2);
		chk("status_stop", 16'h0041, o_bus_ctrl_status_reg);
		i_bus_stop = 0;
		cyc(2);
		chk("stop_on", 1, o_bus_irq);
		chk("flag", 16'h0060, o_ext_irq_flag_reg);
		flagw(8'h00);
		i_ext_irq_enable_reg = 8'hFD;
		i_bus_done = 0;
		cyc(1);
		i_bus_done = 1;
		cyc(2);
		chk("done_off", 0, o_bus_irq);
		tally_and_finish;
	end
endmodule // tb_top
